/* logic/cpu_io_pkg.sv */
// Constants shared by the I/O and DMA interface block.
// Assumes a 25 MHz APB clock and low-true external pins.
package cpu_io_pkg;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_ACC    = 8'h00;
    localparam logic [7:0] OFF_INSTR  = 8'h04;
    localparam logic [7:0] OFF_CTRL   = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_MADDR  = 8'h10;
    localparam logic [7:0] OFF_MDATA  = 8'h14;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_GO    = 0;
    localparam int ST_SKIP    = 0;
    localparam int ST_IOERR   = 1;
    localparam int ST_IRQ     = 2;
    localparam int ST_BUSY    = 3;
    localparam int ST_DMA     = 4;

    // ---------------------------------------------------------------
    // Instruction codes
    // ---------------------------------------------------------------
    localparam logic [3:0] OP_IO      = 4'h1;
    localparam logic [2:0] SUB_SDF    = 3'h1;
    localparam logic [2:0] SUB_DST    = 3'h2;
    localparam logic [2:0] SUB_TFA    = 3'h3;
    localparam logic [2:0] SUB_TTA    = 3'h4;

    // ---------------------------------------------------------------
    // Timing phases and reset values
    // ---------------------------------------------------------------
    localparam logic [2:0] PH_ZERO    = 3'h0;
    localparam logic [2:0] PH_FOUR    = 3'h4;
    localparam logic [2:0] PH_EXEC    = 3'h7;
    localparam logic [7:0] PH_ONE     = 8'h01;
    localparam logic [7:0] TP_RST     = 8'hFE;

endpackage

/* logic/cpu_io_dma.sv */
// CPU side of the parallel I/O port and DMA entry, with an APB slave.
// Assumes all pins are synchronous to pclk and the far side obeys the phases.
//
// How it works
// - accumulator always driven, inverted, on the output data lines
// - skip-no-flag executes next if flag low, else skips
// - DMA write stores the supplied data word in memory
// - accepted device ready pulses the acknowledge and forces no skip
// - input-status decode of bits 5-7 is driven out
// - DMA read drives the read word onto the data outputs
// - direction pin low means write, high means read
// - DMA request low starts an access at the next phase four
// - interrupt input low enters interrupt when instruction ends
// - device ready low during skip instructions means do not skip
// - input lines load the accumulator only on transmit-to-A
// - fault input low sets the sticky I/O error status bit
// - I/O decode output active only while bits 8-11 equal 0001
// - grant output asserted while the DMA access runs
// - eight timing phases are driven out, one low at a time
// - instruction bits 0-7 are driven out continuously
// - skip-no-flag decode of bits 5-7 is driven out
// - transfer decode of bits 5-7 is driven out
// - transmit-to-A decode of bits 5-7 is driven out
// - all I/O port and DMA pins low-true; a floating high input reads as zero
// - grant stays low while the DMA channel holds memory
`timescale 1ns/1ps
`default_nettype none

module cpu_io_dma
    import cpu_io_pkg::*;
#(
    parameter int W  = 12,
    parameter int AW = 12
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    // Programmed I/O port, low true
    output var  logic [W-1:0]  accum_out_lines_n,
    input  wire logic [W-1:0]  io_data_in_n,
    output var  logic [7:0]    instr_bits_out_n,
    output var  logic          io_instr_decode_n,
    output var  logic          skip_no_flag_decode_n,
    output var  logic          input_status_decode_n,
    output var  logic          transfer_a_decode_n,
    output var  logic          transmit_acc_decode_n,
    output var  logic          ready_ack_out_n,
    input  wire logic          device_flag_in_n,
    input  wire logic          device_ready_in_n,
    input  wire logic          io_fault_in_n,
    input  wire logic          external_irq_in_n,
    output var  logic [7:0]    timing_phase_out_n,
    // DMA entry, low true
    input  wire logic [AW-1:0] ext_mem_addr_in_n,
    input  wire logic [W-1:0]  ext_mem_wdata_in_n,
    input  wire logic          ext_mem_dir_in_n,
    input  wire logic          ext_mem_request_in_n,
    output var  logic [W-1:0]  ext_mem_rdata_out_n,
    output var  logic          ext_mem_grant_out_n
);
    import cpu_io_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0]    ph;
        logic [7:0]    tp_n;
        logic [W-1:0]  acc;
        logic [W-1:0]  acc_n;
        logic [W-1:0]  ir;
        logic [7:0]    ir_n;
        logic          iop_n;
        logic          sdf_n;
        logic          dst_n;
        logic          tfa_n;
        logic          tta_n;
        logic          busy;
        logic          skip;
        logic          ioerr;
        logic          irq;
        logic          rdy_ack_n;
        logic          dma_act;
        logic          grant_n;
        logic [W-1:0]  rdata_n;
        logic [AW-1:0] mem_addr;
        logic          pready;
        logic [31:0]   prdata;
        logic          pslverr;
    } state_t;

    state_t        state;
    state_t        next_state;
    logic [W-1:0]  mem [0:(1<<AW)-1];

    // Pins are low true, so invert once here
    logic [AW-1:0] dma_addr;
    logic [W-1:0]  dma_wdata;
    logic          dma_req;
    logic          dma_wr;
    logic          bus_wr;
    logic          exec;
    logic          sub_skip;
    logic          rdy;

    assign dma_addr  = ~ext_mem_addr_in_n;
    assign dma_wdata = ~ext_mem_wdata_in_n;
    assign dma_req   = ~ext_mem_request_in_n;
    assign dma_wr    = dma_req && !ext_mem_dir_in_n && state.ph == PH_FOUR;
    assign bus_wr    = psel && penable && state.pready && pwrite;
    assign exec      = state.busy && state.ph == PH_EXEC;
    assign rdy       = !device_ready_in_n;

    function automatic logic sub_dec_n(input logic [W-1:0] ir, input logic [2:0] code);
        sub_dec_n = !(ir[7:5] == code);
    endfunction

    assign sub_skip  = !sub_dec_n(state.ir, SUB_SDF) || !sub_dec_n(state.ir, SUB_DST);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.ph = state.ph + 3'h1;
        // one phase low at a time
        next_state.tp_n = ~(PH_ONE << next_state.ph);

        // request sampled at phase four only
        if (state.ph == PH_FOUR) begin
            next_state.dma_act = dma_req;
            // read word presented to the DMA party
            if (dma_req && ext_mem_dir_in_n) begin
                next_state.rdata_n = ~mem[dma_addr];
            end
        end
        // held until the next phase four
        next_state.grant_n = !next_state.dma_act;

        // One wait state; never complete on a phase-four edge so that
        // a bus memory write cannot collide with a DMA write
        next_state.pready  = 1'b0;
        next_state.pslverr = 1'b0;
        if (psel && penable && !state.pready && next_state.ph != PH_FOUR) begin
            next_state.pready = 1'b1;
            next_state.prdata = 32'h0000_0000;
            case (paddr)
                OFF_ACC: begin
                    next_state.prdata[W-1:0] = state.acc;
                end
                OFF_INSTR: begin
                    next_state.prdata[W-1:0] = state.ir;
                end
                OFF_CTRL: begin
                    next_state.prdata[CTRL_GO] = state.busy;
                end
                OFF_STATUS: begin
                    next_state.prdata[ST_SKIP]  = state.skip;
                    next_state.prdata[ST_IOERR] = state.ioerr;
                    next_state.prdata[ST_IRQ]   = state.irq;
                    next_state.prdata[ST_BUSY]  = state.busy;
                    next_state.prdata[ST_DMA]   = state.dma_act;
                end
                OFF_MADDR: begin
                    next_state.prdata[AW-1:0] = state.mem_addr;
                end
                OFF_MDATA: begin
                    next_state.prdata[W-1:0] = mem[state.mem_addr];
                end
                default: begin
                    next_state.pslverr = 1'b1;
                end
            endcase
        end

        if (bus_wr) begin
            case (paddr)
                OFF_ACC: begin
                    next_state.acc = pwdata[W-1:0];
                end
                OFF_INSTR: begin
                    next_state.ir = pwdata[W-1:0];
                end
                OFF_CTRL: begin
                    if (pwdata[CTRL_GO]) begin
                        next_state.busy = 1'b1;
                    end
                end
                OFF_STATUS: begin
                    if (pwdata[ST_IOERR]) begin
                        next_state.ioerr = 1'b0;
                    end
                    if (pwdata[ST_IRQ]) begin
                        next_state.irq = 1'b0;
                    end
                end
                OFF_MADDR: begin
                    next_state.mem_addr = pwdata[AW-1:0];
                end
                default: begin
                end
            endcase
        end

        // Instruction executes in the last phase of the cycle
        next_state.rdy_ack_n = 1'b1;
        if (exec) begin
            next_state.busy = 1'b0;
            next_state.skip = 1'b0;
            if (state.ir[11:8] == OP_IO) begin
                if (sub_skip && rdy) begin
                    // ready low means do not skip
                    next_state.rdy_ack_n = 1'b0;
                end else if (!sub_dec_n(state.ir, SUB_SDF)) begin
                    next_state.skip = device_flag_in_n;
                end else if (sub_skip) begin
                    next_state.skip = 1'b1;
                end
                if (!sub_dec_n(state.ir, SUB_TTA)) begin
                    next_state.acc = ~io_data_in_n;
                end
            end
            // interrupt taken at instruction end, set beats clear
            if (!external_irq_in_n) begin
                next_state.irq = 1'b1;
            end
        end

        if (!io_fault_in_n) begin
            next_state.ioerr = 1'b1;
        end

        // accumulator driven out at all times
        next_state.acc_n = ~next_state.acc;
        // instruction bits out at all times
        next_state.ir_n  = ~next_state.ir[7:0];
        next_state.iop_n = !(next_state.ir[11:8] == OP_IO);
        next_state.sdf_n = sub_dec_n(next_state.ir, SUB_SDF);
        next_state.dst_n = sub_dec_n(next_state.ir, SUB_DST);
        next_state.tfa_n = sub_dec_n(next_state.ir, SUB_TFA);
        next_state.tta_n = sub_dec_n(next_state.ir, SUB_TTA);
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= '0;
            state.tp_n      <= TP_RST;
            state.acc_n     <= '1;
            state.ir_n      <= '1;
            state.iop_n     <= 1'b1;
            state.sdf_n     <= 1'b1;
            state.dst_n     <= 1'b1;
            state.tfa_n     <= 1'b1;
            state.tta_n     <= 1'b1;
            state.rdy_ack_n <= 1'b1;
            state.grant_n   <= 1'b1;
            state.rdata_n   <= '1;
        end else begin
            state <= next_state;
        end
    end

    // DMA write stored; DMA has priority over the bus
    always_ff @(posedge pclk) begin
        if (dma_wr) begin
            mem[dma_addr] <= dma_wdata;
        end else if (bus_wr && paddr == OFF_MDATA) begin
            mem[state.mem_addr] <= pwdata[W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign prdata                = state.prdata;
    assign pready                = state.pready;
    assign pslverr               = state.pslverr;
    assign accum_out_lines_n     = state.acc_n;
    assign instr_bits_out_n      = state.ir_n;
    assign io_instr_decode_n     = state.iop_n;
    assign skip_no_flag_decode_n = state.sdf_n;
    assign input_status_decode_n = state.dst_n;
    assign transfer_a_decode_n   = state.tfa_n;
    assign transmit_acc_decode_n = state.tta_n;
    assign ready_ack_out_n       = state.rdy_ack_n;
    assign timing_phase_out_n    = state.tp_n;
    assign ext_mem_rdata_out_n   = state.rdata_n;
    assign ext_mem_grant_out_n   = state.grant_n;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_acc_out;
        @(posedge pclk) disable iff (!presetn)
        accum_out_lines_n == ~state.acc;
    endproperty
    a_acc_out: assert property (p_acc_out) else $error("acc lines mismatch");

    property p_phase;
        @(posedge pclk) disable iff (!presetn)
        (timing_phase_out_n == ~(PH_ONE << state.ph)) and (state.ph == PH_EXEC |=> state.ph == PH_ZERO);
    endproperty
    a_phase: assert property (p_phase) else $error("phase outputs wrong");

    property p_iop;
        @(posedge pclk) disable iff (!presetn)
        !io_instr_decode_n == (state.ir[11:8] == OP_IO);
    endproperty
    a_iop: assert property (p_iop) else $error("io decode wrong");

    property p_irbits;
        @(posedge pclk) disable iff (!presetn)
        instr_bits_out_n == ~state.ir[7:0] && !skip_no_flag_decode_n == (state.ir[7:5] == SUB_SDF);
    endproperty
    a_irbits: assert property (p_irbits) else $error("ir outputs wrong");

    property p_grant;
        @(posedge pclk) disable iff (!presetn)
        state.ph == PH_FOUR && dma_req |=> !ext_mem_grant_out_n [*8];
    endproperty
    a_grant: assert property (p_grant) else $error("grant not held");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        $fell(ext_mem_grant_out_n) |-> $past(state.ph) == PH_FOUR;
    endproperty
    a_start: assert property (p_start) else $error("dma start off phase");

    property p_skip;
        @(posedge pclk) disable iff (!presetn)
        exec && !state.iop_n && !state.sdf_n && !rdy |=> state.skip == $past(device_flag_in_n);
    endproperty
    a_skip: assert property (p_skip) else $error("skip result wrong");

    property p_ready;
        @(posedge pclk) disable iff (!presetn)
        exec && state.ir[11:8] == OP_IO && sub_skip && rdy |=> !ready_ack_out_n && !state.skip ##1 ready_ack_out_n;
    endproperty
    a_ready: assert property (p_ready) else $error("ready ack wrong");

    property p_ioerr;
        @(posedge pclk) disable iff (!presetn)
        !io_fault_in_n |=> state.ioerr;
    endproperty
    a_ioerr: assert property (p_ioerr) else $error("io error not set");

    property p_tta;
        @(posedge pclk) disable iff (!presetn)
        exec && !state.iop_n && !state.tta_n |=> state.acc == ~$past(io_data_in_n);
    endproperty
    a_tta: assert property (p_tta) else $error("acc not loaded");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        exec && !external_irq_in_n |=> state.irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not taken");

    c_dma_rd: cover property (@(posedge pclk) state.ph == PH_FOUR && dma_req && ext_mem_dir_in_n);
    c_dma_wr: cover property (@(posedge pclk) dma_wr);
    c_skip:   cover property (@(posedge pclk) exec ##1 state.skip);
    c_ack:    cover property (@(posedge pclk) !ready_ack_out_n);

endmodule

`default_nettype wire

/* verif/far_device.sv */
// Far-side model: device logic on the I/O port and a DMA requester.
// Assumes the block's phase outputs; the bench sets levels and DMA jobs.
`timescale 1ns/1ps
`default_nettype none

module far_device (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench commands, active high
    input  wire logic        flag,
    input  wire logic        ready,
    input  wire logic        fault,
    input  wire logic        irq,
    input  wire logic [11:0] data,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [11:0] addr,
    input  wire logic [11:0] wdata,
    output var  logic        done,
    output var  logic [11:0] rdata,
    // Block pins, low true
    input  wire logic [7:0]  timing_phase_out_n,
    input  wire logic        ext_mem_grant_out_n,
    input  wire logic [11:0] ext_mem_rdata_out_n,
    output var  logic        device_flag_in_n,
    output var  logic        device_ready_in_n,
    output var  logic        io_fault_in_n,
    output var  logic        external_irq_in_n,
    output var  logic [11:0] io_data_in_n,
    output var  logic        ext_mem_request_in_n,
    output var  logic        ext_mem_dir_in_n,
    output var  logic [11:0] ext_mem_addr_in_n,
    output var  logic [11:0] ext_mem_wdata_in_n
);
    logic held;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {device_flag_in_n, device_ready_in_n, io_fault_in_n, external_irq_in_n} <= 4'hF;
            io_data_in_n         <= 12'hFFF;
            ext_mem_request_in_n <= 1'b1;
            ext_mem_dir_in_n     <= 1'b1;
            ext_mem_addr_in_n    <= 12'hFFF;
            ext_mem_wdata_in_n   <= 12'hFFF;
            held                 <= 1'b0;
            done                 <= 1'b0;
            rdata                <= 12'h000;
        end else begin
            done <= 1'b0;
            // levels move only at phase zero
            if (!timing_phase_out_n[0]) begin
                device_flag_in_n  <= ~flag;
                device_ready_in_n <= ~ready;
                io_fault_in_n     <= ~fault;
                external_irq_in_n <= ~irq;
                io_data_in_n      <= ~data;
                // job held until the phase zero after the grant
                if (held) begin
                    ext_mem_dir_in_n   <= 1'b1;
                    ext_mem_addr_in_n  <= 12'hFFF;
                    ext_mem_wdata_in_n <= 12'hFFF;
                    held               <= 1'b0;
                end else if (go) begin
                    ext_mem_request_in_n <= 1'b0;
                    ext_mem_dir_in_n     <= ~wr;
                    ext_mem_addr_in_n    <= ~addr;
                    ext_mem_wdata_in_n   <= wr ? ~wdata : 12'hFFF;
                end
            end
            // take the read word in the first granted cycle
            if (!ext_mem_grant_out_n && !timing_phase_out_n[5] && !ext_mem_request_in_n) begin
                rdata                <= ~ext_mem_rdata_out_n;
                ext_mem_request_in_n <= 1'b1;
                held                 <= 1'b1;
                done                 <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/cpu_io_dma_interface_tb.sv */
// Self-checking bench for the I/O port and DMA entry block.
// Assumes far_device on the far side and APB driven by this bench.
`timescale 1ns/1ps
`default_nettype none

module cpu_io_dma_interface_tb;
    import cpu_io_pkg::*;

    typedef struct packed {
        logic [11:0] ir;
        logic        flag;
        logic        rdy;
        logic [4:0]  dec;
        logic        skip;
        logic        ack;
        logic [11:0] acc;
    } row_t;

    row_t rows [9] = '{
        '{12'h120, 1'b1, 1'b0, 5'h07, 1'b0, 1'b0, 12'h0F0},
        '{12'h120, 1'b0, 1'b0, 5'h07, 1'b1, 1'b0, 12'h0F0},
        '{12'h120, 1'b0, 1'b1, 5'h07, 1'b0, 1'b1, 12'h0F0},
        '{12'h140, 1'b0, 1'b0, 5'h0B, 1'b1, 1'b0, 12'h0F0},
        '{12'h140, 1'b0, 1'b1, 5'h0B, 1'b0, 1'b1, 12'h0F0},
        '{12'h160, 1'b0, 1'b0, 5'h0D, 1'b0, 1'b0, 12'h0F0},
        '{12'h180, 1'b0, 1'b0, 5'h0E, 1'b0, 1'b0, 12'h5A3},
        '{12'h080, 1'b0, 1'b0, 5'h1E, 1'b0, 1'b0, 12'h0F0},
        '{12'h2FF, 1'b0, 1'b0, 5'h1F, 1'b0, 1'b0, 12'h0F0}
    };

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, instr_bits_out_n, timing_phase_out_n;
    logic [31:0] pwdata, prdata, q;
    logic [11:0] accum_out_lines_n, io_data_in_n, ext_mem_rdata_out_n;
    logic [11:0] ext_mem_addr_in_n, ext_mem_wdata_in_n, data, addr, wdata, rdata;
    logic        io_instr_decode_n, skip_no_flag_decode_n, input_status_decode_n;
    logic        transfer_a_decode_n, transmit_acc_decode_n, ready_ack_out_n;
    logic        device_flag_in_n, device_ready_in_n, io_fault_in_n, external_irq_in_n;
    logic        ext_mem_dir_in_n, ext_mem_request_in_n, ext_mem_grant_out_n;
    logic        flag, ready, fault, irq, go, wr, done;
    logic [4:0]  dec_n;
    int          miscompares, n_tests, ack_cnt, g_run, g_last;

    assign dec_n = {io_instr_decode_n, skip_no_flag_decode_n, input_status_decode_n,
                    transfer_a_decode_n, transmit_acc_decode_n};

    cpu_io_dma cpu_io_dma_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .accum_out_lines_n, .io_data_in_n, .instr_bits_out_n, .io_instr_decode_n,
        .skip_no_flag_decode_n, .input_status_decode_n, .transfer_a_decode_n,
        .transmit_acc_decode_n, .ready_ack_out_n, .device_flag_in_n, .device_ready_in_n,
        .io_fault_in_n, .external_irq_in_n, .timing_phase_out_n, .ext_mem_addr_in_n,
        .ext_mem_wdata_in_n, .ext_mem_dir_in_n, .ext_mem_request_in_n,
        .ext_mem_rdata_out_n, .ext_mem_grant_out_n
    );

    far_device far_device_i (
        .pclk, .presetn, .flag, .ready, .fault, .irq, .data, .go, .wr, .addr, .wdata,
        .done, .rdata, .timing_phase_out_n, .ext_mem_grant_out_n, .ext_mem_rdata_out_n,
        .device_flag_in_n, .device_ready_in_n, .io_fault_in_n, .external_irq_in_n,
        .io_data_in_n, .ext_mem_request_in_n, .ext_mem_dir_in_n, .ext_mem_addr_in_n,
        .ext_mem_wdata_in_n
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Acknowledge pulses and grant lengths, seen at each edge
    always @(posedge pclk) begin
        if (ready_ack_out_n === 1'b0) ack_cnt++;
        if (ext_mem_grant_out_n === 1'b0) begin
            if (g_run == 0) check(timing_phase_out_n[5], 1'b0);
            g_run++;
        end else if (g_run != 0) begin
            g_last = g_run;
            g_run  = 0;
        end
    end

    // ----------
    // Tasks
    // ----------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic fail_wait;
        miscompares++;
        final_report();
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // Holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) fail_wait();
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wt(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic run_row(input row_t r);
        int n;
        flag  <= r.flag;
        ready <= r.rdy;
        wt(OFF_ACC, 32'h0F0);
        wt(OFF_INSTR, {20'hFFFFF, r.ir});
        rd(OFF_INSTR);
        check(q, {20'h0, r.ir});
        cyc(10);
        check(dec_n, r.dec);
        check(instr_bits_out_n, {~r.ir[7:0]});
        ack_cnt = 0;
        wt(OFF_CTRL, 32'h1);
        n = 0;
        do begin
            rd(OFF_STATUS);
            n++;
        end while (q[ST_BUSY] !== 1'b0 && n < 8);
        if (q[ST_BUSY] !== 1'b0) fail_wait();
        if (r.ir[11:8] == OP_IO && r.ir[7:5] inside {SUB_SDF, SUB_DST})
            check(q[ST_SKIP], r.skip);
        check(ack_cnt, r.ack);
        rd(OFF_ACC);
        check(q, {20'h0, r.acc});
        check(accum_out_lines_n, {~r.acc});
    endtask

    task automatic dma(input logic w, input logic [11:0] a, input logic [11:0] d);
        int n;
        wr     <= w;
        addr   <= a;
        wdata  <= d;
        go     <= 1'b1;
        g_last = 0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (done !== 1'b1 && n < 24);
        go <= 1'b0;
        if (done !== 1'b1) fail_wait();
        cyc(12);
        check(g_last, 8);
    endtask

    // ----------
    // Sequence
    // ----------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {flag, ready, fault, irq, go, wr, addr, wdata} = '0;
        data = 12'h5A3;
        {miscompares, n_tests, ack_cnt, g_run, g_last} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        rd(OFF_STATUS);
        check(q[ST_IRQ:ST_IOERR], 2'b00);
        rd(8'h18);
        check(err, 1'b1);
        check(q, 32'h0);
        wt(8'h18, 32'h5);
        check(err, 1'b1);
        rd(OFF_ACC);
        check(q, 32'h0F0);
        irq <= 1'b1;
        run_row(rows[0]);
        irq <= 1'b0;
        rd(OFF_STATUS);
        check(q[ST_IRQ], 1'b1);
        wt(OFF_STATUS, 32'h4);
        rd(OFF_STATUS);
        check(q[ST_IRQ], 1'b0);
        fault <= 1'b1;
        cyc(10);
        rd(OFF_STATUS);
        check(q[ST_IOERR], 1'b1);
        fault <= 1'b0;
        cyc(10);
        wt(OFF_STATUS, 32'h2);
        rd(OFF_STATUS);
        check(q[ST_IOERR], 1'b0);
        wt(OFF_MADDR, 32'h010);
        wt(OFF_MDATA, 32'h777);
        dma(1'b0, 12'h010, 12'h000);
        check(rdata, 12'h777);
        dma(1'b1, 12'h3C5, 12'hA5A);
        wt(OFF_MADDR, 32'h3C5);
        rd(OFF_MDATA);
        check(q, 32'hA5A);
        // Reset again in mid-run, then walk the phases
        @(posedge pclk);
        presetn <= 1'b0;
        cyc(2);
        check(timing_phase_out_n, TP_RST);
        check({accum_out_lines_n, ext_mem_grant_out_n, ready_ack_out_n}, 14'h3FFF);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 1; k < 9; k++) begin
            @(posedge pclk);
            check(timing_phase_out_n, {~(PH_ONE << (k % 8))});
        end
        final_report();
    end
endmodule
`default_nettype wire
